/* File: mbmc_ctrl.sv */
`timescale 1ns/1ns
`include "mbmc_defs.svh"
// How it works
// R1 - decode accesses into eight configurable banks
// R2 - zero-wait static access takes two cycles
// R3 - block size from 32 kbyte to 256 mbyte
// R4 - per-bank wait states zero to thirty
// R5 - bank match optionally qualified by address type
// R6 - four byte enables plus one output enable
// R7 - boot select usable straight out of reset
// R8 - wide transfers split for narrow ports
// R9 - dram depths 256k to 64m, any port
// R10 - extra dram depths for 8/32-bit ports
// R11 - burst beats use page mode, row open
// R12 - cas-before-ras refresh from programmable timer
// R13 - refresh continues during external reset
// R14 - disable mode stops new refresh requests; pending ones still run
// R15 - up to seven pending refreshes, back to back
// R16 - strobe waveforms from programmed state machine
// R17 - one dram bank direct, more need buffers
// R18 - select is chip select or row strobe
// R19 - pending refresh first; count saturates
module mbmc_ctrl (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // system bus request
  input  wire logic                  req_valid,
  output      logic                  req_ready,
  input  wire logic [31:0]           req_addr,
  input  wire logic                  req_write,
  input  wire logic [1:0]            req_size,
  input  wire logic                  req_burst,
  input  wire logic [3:0]            req_atype,
  input  wire logic [31:0]           req_wdata,
  // answer
  output      logic                  rsp_valid,
  output      logic                  rsp_error,
  output      logic [31:0]           rsp_rdata,
  // configuration
  input  wire mbmc_pkg::mbmc_bank_type bank_cfg [`MBMC_NBANK],
  input  wire logic                  cfg_commit,
  input  wire logic [1:0]            boot_port,
  input  wire mbmc_pkg::mbmc_wf_type wf_table [`MBMC_WF_N],
  input  wire logic [15:0]           ref_period,
  input  wire logic                  ref_disable,
  input  wire logic                  ext_reset,
  // memory pins
  output      logic [7:0]            mem_cs_n,
  output      logic [3:0]            mem_be_n,
  output      logic                  mem_oe_n,
  output      logic                  mem_we_n,
  output      logic                  mem_amux,
  output      logic [31:0]           mem_addr,
  output      logic [31:0]           mem_wdata,
  input  wire logic [31:0]           mem_rdata,
  // status
  output      logic                  boot_active,
  output      logic [2:0]            ref_pending
);
  mbmc_pkg::mbmc_state_type r_ff, nxt_r;       // registered state and next copy
  mbmc_pkg::mbmc_bank_type  cfg [`MBMC_NBANK]; // effective bank settings
  logic [`MBMC_NBANK-1:0]   hit;               // per-bank match
  logic [`MBMC_NBANK-1:0]   dmask;             // banks wired as dram
  logic [2:0]               hsel;              // winning bank
  logic                     any_hit;
  logic                     req_fire;
  logic                     tick, bend, dec, start, inc;
  mbmc_pkg::mbmc_wf_type    e_cur, e_nx;       // waveform entries now and next
  logic [1:0]               lbw, k, off, nk, noff;
  logic [4:0]               sh, beats;
  logic [31:0]              baddr, nb, rd_part;
  logic [3:0]               bemask;

  // log2 of beats per word for a request size on a port
  function automatic logic [1:0] f_lbw(logic [1:0] s, logic [1:0] p);
    return (s > p) ? 2'(s - p) : 2'h0;
  endfunction : f_lbw

  // byte lane of an address on a port
  function automatic logic [1:0] f_off(logic [31:0] a, logic [1:0] p);
    return a[1:0] & {p[1], |p};
  endfunction : f_off

  // lane mask for a size or port code
  function automatic logic [3:0] f_mask(logic [1:0] c);
    return c[1] ? 4'hf : (c[0] ? 4'h3 : 4'h1);
  endfunction : f_mask

  // dram depth legality; an illegal bank never matches
  function automatic logic depth_ok(mbmc_pkg::mbmc_bank_type c);
    return (c.blk <= `MBMC_BLK_MAX) && (!c.dram                              // [R3]
      || (c.blk >= `MBMC_DR_MIN && c.blk <= `MBMC_DR_MAX)                    // [R9]
      || (c.port == `MBMC_PS8 && c.blk >= `MBMC_DR_NAR && c.blk < `MBMC_DR_MIN) // [R10]
      || (c.port == `MBMC_PS32 && c.blk >= `MBMC_DR_WIDE));                  // [R10]
  endfunction : depth_ok

  // per-bank decode, bank 0 overridden while booting
  for (genvar i = 0; i < `MBMC_NBANK; i++) begin : g_bank
    always_comb begin
      cfg[i] = bank_cfg[i];
      if (i == 0 && r_ff.boot) begin // [R7]
        cfg[i]       = '0;
        cfg[i].valid = 1'b1;
        cfg[i].blk   = `MBMC_BLK_MAX;
        cfg[i].ws    = `MBMC_BOOT_WS;
        cfg[i].port  = r_ff.bsize;
      end
    end
    assign dmask[i] = cfg[i].valid & cfg[i].dram;
    assign hit[i]   = cfg[i].valid && depth_ok(cfg[i])                                   // [R1]
      && (((req_addr[31:`MBMC_BLK_LSB] ^ cfg[i].base) & (`MBMC_BLK_ALL << cfg[i].blk)) == '0) // [R3]
      && (!cfg[i].atype_en || cfg[i].atype == req_atype);                                // [R5]
  end

  // lowest matching bank wins
  always_comb begin
    hsel = 3'h0;
    for (int j = `MBMC_NBANK - 1; j >= 0; j--) begin
      if (hit[j]) hsel = 3'(j);
    end
  end
  assign any_hit = |hit;

  // new accesses wait behind refresh and external reset
  assign req_ready = (r_ff.st == mbmc_pkg::ST_IDLE) && (r_ff.pend == '0) && !ext_reset; // [R19]
  assign req_fire  = req_valid && req_ready;

  // next-state logic
  always_comb begin
    nxt_r       = r_ff;
    nxt_r.rsp_v = 1'b0;
    nxt_r.rsp_e = 1'b0;
    tick        = 1'b0;
    bend        = 1'b0;
    dec         = 1'b0;
    start       = 1'b0;
    beats       = 5'h0;
    e_cur       = wf_table[r_ff.wfi];
    // refresh timer, held at reload while disabled
    if (ref_disable) begin // [R14]
      nxt_r.rcnt = ref_period;
    end else if (r_ff.rcnt == '0) begin // [R12]
      nxt_r.rcnt = ref_period;
      tick       = 1'b1;
    end else begin
      nxt_r.rcnt = r_ff.rcnt - 16'h1;
    end
    // lanes of the beat in flight
    lbw     = f_lbw(r_ff.sz, r_ff.port);
    k       = r_ff.beat[1:0] & {lbw[1], |lbw};
    baddr   = r_ff.addr + (32'(r_ff.beat) << r_ff.port);
    off     = f_off(baddr, r_ff.port);
    sh      = {k, 3'b000} << r_ff.port;
    // keep only the lanes of the smaller of request and port, so a byte read is not padded with neighbours
    rd_part = (mem_rdata >> {off, 3'b000})
              & ~(32'hffffffff << (6'h8 << ((r_ff.sz < r_ff.port) ? r_ff.sz : r_ff.port))); // [R8]
    case (r_ff.st)
      mbmc_pkg::ST_IDLE: begin
        if (r_ff.pend != '0) begin // [R19]
          nxt_r.st  = mbmc_pkg::ST_REF;
          nxt_r.wfi = `MBMC_WF_REF;
        end else if (req_fire && !any_hit) begin
          nxt_r.rsp_v = 1'b1; // unmapped address
          nxt_r.rsp_e = 1'b1;
        end else if (req_fire) begin
          nxt_r.bank  = hsel;
          nxt_r.addr  = req_addr;
          nxt_r.wr    = req_write;
          nxt_r.sz    = (req_size > `MBMC_SZ_WORD) ? `MBMC_SZ_WORD : req_size;
          nxt_r.port  = (cfg[hsel].port > `MBMC_PS32) ? `MBMC_PS32 : cfg[hsel].port;
          nxt_r.dram  = cfg[hsel].dram; // [R18]
          nxt_r.ws    = (cfg[hsel].ws > `MBMC_WS_MAX) ? `MBMC_WS_MAX : cfg[hsel].ws; // [R4]
          // narrow ports take several beats per word; read bursts four words
          beats       = ((req_burst && !req_write) ? `MBMC_BURST_WORDS : 5'h1)
                        << f_lbw(nxt_r.sz, nxt_r.port); // [R8] [R2]
          nxt_r.lastb = 4'(beats - 5'h1);
          nxt_r.beat  = 4'h0;
          nxt_r.acc   = '0;
          nxt_r.wdat  = req_wdata;
          start       = 1'b1;
        end
      end
      mbmc_pkg::ST_ACC: begin
        if (r_ff.wt != '0) nxt_r.wt = r_ff.wt - 5'h1; // [R4]
        else bend = 1'b1;
      end
      mbmc_pkg::ST_DRAM: begin
        if (e_cur.last) bend = 1'b1; // [R16]
        else nxt_r.wfi = r_ff.wfi + 4'h1;
      end
      mbmc_pkg::ST_REF: begin
        if (e_cur.last) begin
          dec = 1'b1;
          if (r_ff.pend > 3'h1) nxt_r.wfi = `MBMC_WF_REF; // [R15]
          else nxt_r.st = mbmc_pkg::ST_IDLE;
        end else begin
          nxt_r.wfi = r_ff.wfi + 4'h1;
        end
      end
      default: nxt_r.st = mbmc_pkg::ST_IDLE;
    endcase
    // end of a beat: gather read data, answer per word
    if (bend) begin
      nxt_r.acc = r_ff.acc | (rd_part << sh); // [R8]
      if (k == {lbw[1], |lbw}) begin
        nxt_r.rsp_v = 1'b1;
        nxt_r.rsp_d = nxt_r.acc;
        nxt_r.acc   = '0;
      end
      if (r_ff.beat == r_ff.lastb) begin
        nxt_r.st = mbmc_pkg::ST_IDLE;
      end else begin
        nxt_r.beat = r_ff.beat + 4'h1;
        start      = 1'b1;
      end
    end
    // launch a beat; later dram beats reuse the open row
    if (start) begin
      nxt_r.st  = nxt_r.dram ? mbmc_pkg::ST_DRAM : mbmc_pkg::ST_ACC;
      nxt_r.wt  = nxt_r.ws;
      nxt_r.wfi = (nxt_r.beat == '0) ? `MBMC_WF_ACC : `MBMC_WF_PAGE; // [R11]
    end
    // external reset aborts accesses but refresh carries on
    if (ext_reset) begin // [R13]
      if (nxt_r.st == mbmc_pkg::ST_ACC || nxt_r.st == mbmc_pkg::ST_DRAM) nxt_r.st = mbmc_pkg::ST_IDLE;
      nxt_r.boot = 1'b1;
    end else if (cfg_commit) begin
      nxt_r.boot = 1'b0;
    end
    // pending count saturates instead of wrapping
    // a tick in the cycle a refresh retires still counts, so a full stack stays full
    inc        = tick && (r_ff.pend != `MBMC_PEND_MAX || dec); // [R15] [R19]
    nxt_r.pend = r_ff.pend + 3'(inc) - 3'(dec);
    // pins for the coming cycle
    lbw          = f_lbw(nxt_r.sz, nxt_r.port); // reused for the coming beat
    nk           = nxt_r.beat[1:0] & {lbw[1], |lbw}; // [R8]
    nb           = nxt_r.addr + (32'(nxt_r.beat) << nxt_r.port);
    noff         = f_off(nb, nxt_r.port);
    bemask       = (f_mask(nxt_r.sz) & f_mask(nxt_r.port)) << noff; // [R6] [R8]
    e_nx         = wf_table[nxt_r.wfi];
    nxt_r.maddr  = nb;
    nxt_r.mwd    = (nxt_r.wdat >> ({nk, 3'b000} << nxt_r.port)) << {noff, 3'b000};
    nxt_r.cs_n   = `MBMC_CS_OFF;
    nxt_r.be_n   = `MBMC_BE_OFF;
    nxt_r.oe_n   = 1'b1;
    nxt_r.we_n   = 1'b1;
    nxt_r.amux   = 1'b0;
    case (nxt_r.st)
      mbmc_pkg::ST_ACC: begin // plain chip select
        nxt_r.cs_n = ~(`MBMC_CS_ONE << nxt_r.bank); // [R18]
        nxt_r.be_n = ~bemask; // [R6]
        nxt_r.oe_n = nxt_r.wr;
        nxt_r.we_n = ~nxt_r.wr;
      end
      mbmc_pkg::ST_DRAM: begin // select as row strobe, enables as column strobes
        nxt_r.cs_n = ~((`MBMC_CS_ONE << nxt_r.bank) & {8{e_nx.ras | (nxt_r.beat != '0)}}); // [R11] [R16]
        nxt_r.be_n = ~(bemask & {4{e_nx.cas}});
        nxt_r.oe_n = ~(e_nx.oe & ~nxt_r.wr);
        nxt_r.we_n = ~(e_nx.we & nxt_r.wr);
        nxt_r.amux = e_nx.amux;
      end
      mbmc_pkg::ST_REF: begin // all column strobes, every dram row strobe
        nxt_r.cs_n = ~(dmask & {8{e_nx.ras}}); // [R12] [R17]
        nxt_r.be_n = ~{4{e_nx.cas}};
      end
      default: ;
    endcase
  end

  // state register; the boot strap is caught while reset is held
  always_ff @(posedge clk) begin
    if (rst) begin
      r_ff       <= '0;
      r_ff.st    <= mbmc_pkg::ST_IDLE;
      r_ff.cs_n  <= `MBMC_CS_OFF;
      r_ff.be_n  <= `MBMC_BE_OFF;
      r_ff.oe_n  <= 1'b1;
      r_ff.we_n  <= 1'b1;
      r_ff.boot  <= 1'b1;
      r_ff.bsize <= boot_port;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs straight from the state register
  assign rsp_valid   = r_ff.rsp_v;
  assign rsp_error   = r_ff.rsp_e;
  assign rsp_rdata   = r_ff.rsp_d;
  assign mem_cs_n    = r_ff.cs_n;
  assign mem_be_n    = r_ff.be_n;
  assign mem_oe_n    = r_ff.oe_n;
  assign mem_we_n    = r_ff.we_n;
  assign mem_amux    = r_ff.amux;
  assign mem_addr    = r_ff.maddr;
  assign mem_wdata   = r_ff.mwd;
  assign boot_active = r_ff.boot;
  assign ref_pending = r_ff.pend;

  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sram_take;
    req_fire && any_hit && !cfg[hsel].dram && cfg[hsel].ws == '0 && cfg[hsel].port == `MBMC_PS32 && !req_burst;
  endsequence
  sequence s_sram_done;
    (mem_cs_n != `MBMC_CS_OFF) ##1 (rsp_valid && mem_cs_n == `MBMC_CS_OFF);
  endsequence

  a_sram_two_cycle: assert property (s_sram_take |=> s_sram_done) // [R2]
    else $error("zero-wait static access not two cycles");
  a_wait_count: assert property (r_ff.st == mbmc_pkg::ST_ACC && r_ff.wt != '0 && !ext_reset // [R4]
    |=> r_ff.st == mbmc_pkg::ST_ACC && r_ff.wt == $past(r_ff.wt) - 5'h1)
    else $error("wait state count wrong");
  a_boot_select: assert property (r_ff.boot && req_fire && any_hit && hsel == 3'h0 |=> !mem_cs_n[0]) // [R7]
    else $error("boot select not asserted");
  a_pend_sat: assert property (r_ff.pend == `MBMC_PEND_MAX |=> r_ff.pend >= 3'h6) // [R15]
    else $error("pending refresh count wrapped");
  a_ref_first: assert property (r_ff.st == mbmc_pkg::ST_IDLE && r_ff.pend != '0 // [R19]
    |-> !req_ready ##1 r_ff.st == mbmc_pkg::ST_REF)
    else $error("pending refresh not granted first");
  a_ref_off: assert property (ref_disable ##1 ref_disable |-> r_ff.pend <= $past(r_ff.pend)) // [R14]
    else $error("refresh requested while disabled");
  a_ext_refresh: assert property (ext_reset && r_ff.st == mbmc_pkg::ST_IDLE && r_ff.pend != '0 // [R13]
    |=> r_ff.st == mbmc_pkg::ST_REF)
    else $error("refresh stalled by external reset");
  a_page_ras: assert property (r_ff.st == mbmc_pkg::ST_DRAM && r_ff.beat != '0 |-> !mem_cs_n[r_ff.bank]) // [R11]
    else $error("row strobe dropped inside burst");
  a_oe_write: assert property (!mem_oe_n |-> mem_we_n) // [R6]
    else $error("output and write enable together");
endmodule : mbmc_ctrl

/* File: mbmc_defs.svh */
`ifndef MBMC_DEFS_SVH
`define MBMC_DEFS_SVH
// bank count and per-bank limits
`define MBMC_NBANK 8
`define MBMC_WS_MAX 5'h1e
`define MBMC_PEND_MAX 3'h7
// block size: 32 kbyte shifted left by a 4-bit code
`define MBMC_BLK_LSB 15
`define MBMC_BLK_MAX 4'hd
`define MBMC_BLK_ALL 17'h1ffff
// dram depth codes
`define MBMC_DR_NAR 4'h1
`define MBMC_DR_MIN 4'h3
`define MBMC_DR_MAX 4'hb
`define MBMC_DR_WIDE 4'hc
// port and request size codes
`define MBMC_PS8 2'h0
`define MBMC_PS32 2'h2
`define MBMC_SZ_WORD 2'h2
`define MBMC_BURST_WORDS 5'h4
// waveform table layout
`define MBMC_WF_N 16
`define MBMC_WF_ACC 4'h0
`define MBMC_WF_PAGE 4'h8
`define MBMC_WF_REF 4'hc
// boot bank and idle pin levels
`define MBMC_BOOT_WS 5'h1e
`define MBMC_CS_OFF 8'hff
`define MBMC_CS_ONE 8'h01
`define MBMC_BE_OFF 4'hf
`endif

/* File: mbmc_pkg.sv */
`include "mbmc_defs.svh"
package mbmc_pkg;
  // controller states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACC  = 4'h2,
    ST_DRAM = 4'h4,
    ST_REF  = 4'h8
  } mbmc_st_type;

  // one bank's settings
  typedef struct packed {
    logic        valid;
    logic [16:0] base;     // address bits 31..15
    logic [3:0]  blk;      // block size code
    logic [4:0]  ws;       // wait states
    logic [1:0]  port;     // port size code
    logic        atype_en; // qualify by address type
    logic [3:0]  atype;
    logic        dram;     // select acts as row strobe
  } mbmc_bank_type;

  // one waveform table entry, active-high strobes
  typedef struct packed {
    logic last;
    logic amux;
    logic we;
    logic oe;
    logic cas;
    logic ras;
  } mbmc_wf_type;

  // whole controller state
  typedef struct packed {
    mbmc_st_type st;
    logic [2:0]  bank;
    logic [31:0] addr;
    logic        wr;
    logic [1:0]  sz;
    logic [1:0]  port;
    logic        dram;
    logic [4:0]  ws;
    logic [3:0]  lastb;
    logic [3:0]  beat;
    logic [4:0]  wt;
    logic [3:0]  wfi;
    logic [31:0] acc;
    logic [31:0] wdat;
    logic [7:0]  cs_n;
    logic [3:0]  be_n;
    logic        oe_n;
    logic        we_n;
    logic        amux;
    logic [31:0] maddr;
    logic [31:0] mwd;
    logic        rsp_v;
    logic        rsp_e;
    logic [31:0] rsp_d;
    logic [15:0] rcnt;
    logic [2:0]  pend;
    logic        boot;
    logic [1:0]  bsize;
  } mbmc_state_type;
endpackage : mbmc_pkg

/* File: mbmc_mem_model.sv */
`timescale 1ns/1ns
// far-side memory: byte at address x reads back as x[7:0]^3c on every lane
module mbmc_mem_model (
  // clock
  input  wire logic        clk,
  // pins from the controller
  input  wire logic [7:0]  cs_n,
  input  wire logic        oe_n,
  input  wire logic [31:0] addr,
  // read data toward the controller
  output      logic [31:0] rdata
);
  logic [31:0] last_q = 32'h0; // last word driven
  logic        drive;          // a selected device has its output on
  // one bank on the wire, no buffer
  assign drive = (cs_n != 8'hff) && !oe_n;
  // released bus shows the inverse, so a late sample never matches by luck
  assign rdata = drive ? {4{addr[7:0] ^ 8'h3c}} : ~last_q;
  // remember what was driven
  always @(posedge clk) begin
    if (drive) begin
      last_q <= rdata;
    end
  end
endmodule : mbmc_mem_model

/* File: mbmc_ctrl_test.sv */
`timescale 1ns/1ns
`include "mbmc_defs.svh"
module mbmc_ctrl_test;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, mem_addr, mem_wdata, mem_rdata;
  logic [1:0]  req_size = 2'h2, boot_port = 2'h2;
  logic [3:0]  req_atype = 4'h0, mem_be_n, be_s;
  logic [15:0] ref_period = 16'h1;
  logic cfg_commit = 1'b0, ref_disable = 1'b1, ext_reset = 1'b0, req_ready, rsp_valid, rsp_error;
  logic [7:0]  mem_cs_n;
  logic mem_oe_n, mem_we_n, mem_amux, boot_active, we_s, er, am_s, pcs = 1'b1;
  logic [2:0]  ref_pending;
  logic [3:0]  pbe = 4'hf;
  logic [31:0] wd_s, wd_b1, rd [4];
  logic        cs_s [4];
  mbmc_pkg::mbmc_bank_type bank_cfg [`MBMC_NBANK]; // bank settings
  mbmc_pkg::mbmc_wf_type   wf_table [`MBMC_WF_N];  // strobe program
  int n_errors = 0, n_checks = 0, cyc = 0, lat, n_cbr = 0, seed = 32'h830f, ws, c0;
  always #5 clk = ~clk;
  mbmc_ctrl u_dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
    .req_write(req_write), .req_size(req_size), .req_burst(req_burst), .req_atype(req_atype),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .bank_cfg(bank_cfg), .cfg_commit(cfg_commit), .boot_port(boot_port), .wf_table(wf_table),
    .ref_period(ref_period), .ref_disable(ref_disable), .ext_reset(ext_reset), .mem_cs_n(mem_cs_n),
    .mem_be_n(mem_be_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_amux(mem_amux),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .boot_active(boot_active),
    .ref_pending(ref_pending));
  mbmc_mem_model u_mem (.clk(clk), .cs_n(mem_cs_n), .oe_n(mem_oe_n), .addr(mem_addr), .rdata(mem_rdata));
  // byte image of the far-side memory
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : mb
  // one bank setting
  function automatic mbmc_pkg::mbmc_bank_type bk(input logic [16:0] b, input logic [3:0] z,
      input logic [4:0] w, input logic [1:0] p, input logic e, input logic d);
    return '{valid: 1'b1, base: b, blk: z, ws: w, port: p, atype_en: e, atype: 4'h5, dram: d};
  endfunction : bk
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("n_errors %0d n_checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // one request, held until taken, then nr answers collected
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic bu,
      input logic [3:0] at, input logic [31:0] wd, input int nr);
    int n;
    int k;
    req_addr = a; req_write = w; req_size = sz; req_burst = bu; req_atype = at; req_wdata = wd;
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    n = 0;
    k = 0;
    while (k < nr) begin
      @(posedge clk);
      n++;
      if (n == 1) begin
        be_s = mem_be_n; we_s = mem_we_n; wd_s = mem_wdata;
      end
      if (n == 2) am_s = mem_amux;
      if (n == 5) wd_b1 = mem_wdata;
      if (rsp_valid === 1'b1) begin
        if (k == 0) lat = n;
        rd[k] = rsp_rdata; er = rsp_error; cs_s[k] = mem_cs_n[4];
        k++;
      end
    end
    #1;
  endtask : acc
  // hang guard and cas-before-ras counter on the dram bank
  always @(posedge clk) begin
    cyc++;
    if (!mem_cs_n[4] && pcs && pbe == 4'h0) n_cbr++;
    pcs = mem_cs_n[4];
    pbe = mem_be_n;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    foreach (bank_cfg[i]) bank_cfg[i] = '0;
    foreach (wf_table[i]) wf_table[i] = '0;
    bank_cfg[0] = bk(17'h0, 4'h0, 5'h0, 2'h2, 1'b0, 1'b0);
    bank_cfg[1] = bk(17'h1, 4'h0, 5'h3, 2'h0, 1'b0, 1'b0);
    bank_cfg[2] = bk(17'h2, 4'h0, 5'h1, 2'h2, 1'b1, 1'b0);
    bank_cfg[4] = bk(17'h20, 4'h5, 5'h0, 2'h2, 1'b0, 1'b1);
    bank_cfg[5] = bk(17'h40, 4'h0, 5'h0, 2'h2, 1'b0, 1'b1);
    bank_cfg[6] = bk(17'h4000, 4'hd, 5'h0, 2'h2, 1'b0, 1'b0);
    // ras, then column beat; page beat column only; refresh cas first
    wf_table[0] = 6'h01; wf_table[1] = 6'h37; wf_table[8] = 6'h36;
    wf_table[12] = 6'h02; wf_table[13] = 6'h03; wf_table[14] = 6'h23;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1 chk("boot", boot_active, 1);
    chk("ready", req_ready, 1);
    acc(32'h40, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("boot lat", lat, 32);
    chk("boot data", rd[0], {4{mb(32'h40)}});
    cfg_commit = 1'b1;
    @(posedge clk);
    #1 cfg_commit = 1'b0;
    @(posedge clk);
    #1 chk("committed", boot_active, 0);
    acc(32'h7ffc, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("ws0 lat", lat, 2);
    chk("ws0 data", rd[0], {4{mb(32'h7ffc)}});
    acc(32'h8010, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("narrow lat", lat, 17);
    chk("narrow data", rd[0], {mb(32'h8013), mb(32'h8012), mb(32'h8011), mb(32'h8010)});
    acc(32'h18000, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("unmapped", {lat[30:0], er}, 3);
    acc(32'h2ffffffc, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("blk top", er, 0);
    acc(32'h30000000, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("blk out", er, 1);
    acc(32'h10000, 0, 2'h2, 0, 4'h5, 0, 1);
    chk("type hit", {lat[30:0], er}, 6);
    acc(32'h10000, 0, 2'h2, 0, 4'h6, 0, 1);
    chk("type miss", er, 1);
    acc(32'h200000, 0, 2'h2, 0, 4'h0, 0, 1);
    chk("bad depth", er, 1);
    acc(32'h102, 1, 2'h0, 0, 4'h0, 32'ha5, 1);
    chk("byte lane", {we_s, be_s, wd_s[23:16]}, 13'h0ba5);
    // word write to the byte-wide bank: second beat carries the second byte on lane 0
    acc(32'h8000, 1, 2'h2, 0, 4'h0, 32'h44332211, 1);
    chk("narrow write", wd_b1[7:0], 8'h22);
    acc(32'h100000, 0, 2'h2, 1, 4'h0, 0, 4);
    for (int i = 0; i < 4; i++) begin
      chk("burst data", rd[i], {4{mb(32'h100000 + 4 * i)}});
      if (i < 3) chk("row open", cs_s[i], 0);
    end
    chk("col addr", am_s, 1);
    for (int i = 0; i < 6; i++) begin
      ws = $unsigned($random(seed)) % 31;
      bank_cfg[0].ws = 5'(ws);
      c0 = {$random(seed)} % 8192;
      acc(32'(c0 * 4), 0, 2'h2, 0, 4'h0, 0, 1);
      chk("rand lat", lat, 2 + ws);
      chk("rand data", rd[0], {4{mb(32'(c0 * 4))}});
    end
    // refresh ticks pile up behind a long narrow read
    c0 = n_cbr;
    fork
      acc(32'h8000, 0, 2'h2, 0, 4'h0, 0, 1);
      begin
        @(posedge clk);
        #1 ref_disable = 1'b0;
      end
    join
    ref_disable = 1'b1;
    chk("saturate", ref_pending, 7);
    chk("held off", req_ready, 0);
    repeat (60) @(posedge clk);
    chk("drained", n_cbr - c0, 7);
    chk("disabled", ref_pending, 0);
    #1 ext_reset = 1'b1;
    ref_disable = 1'b0;
    c0 = n_cbr;
    repeat (40) @(posedge clk);
    chk("ext boot", boot_active, 1);
    chk("ext ready", req_ready, 0);
    chk("ext refresh", n_cbr > c0, 1);
    close_out();
  end
endmodule : mbmc_ctrl_test
